// ---- pkg/pwc_cfg.svh ----
// Timing constants, field positions and reset values of the power-on control block
`ifndef PWC_CFG_SVH
`define PWC_CFG_SVH

`define PWC_CLK_MHZ 250
`define PWC_SEQ_STEP_US 100
`define PWC_SEQ_STEP_CYC (`PWC_SEQ_STEP_US * `PWC_CLK_MHZ)
`define PWC_RST_FIRST_MS 100
`define PWC_RST_FIRST_CYC (`PWC_RST_FIRST_MS * 1000 * `PWC_CLK_MHZ)
`define PWC_RST_LATER_MS 250
`define PWC_RST_LATER_CYC (`PWC_RST_LATER_MS * 1000 * `PWC_CLK_MHZ)

`define PWC_NUM_REG 9
`define PWC_EN_CORE 0
`define PWC_EN_PAD 1
`define PWC_EN_ANA 2
`define PWC_EN_OSC 3
`define PWC_EN_DEFAULT 9'h00f
`define PWC_EN_OFF 9'h000

`define PWC_ST_PRESENT 0
`define PWC_ST_CHARGING 1
`define PWC_ST_FAULT 2

`define PWC_CODE_W 4
`define PWC_CORE_1V35 4'h0
`define PWC_CORE_1V80 4'h3
`define PWC_PAD_1V80 4'h3
`define PWC_PAD_2V60 4'h8
`define PWC_LN_2V55 4'h0
`define PWC_LN_2V90 4'h7
`define PWC_LN_DEFAULT 4'h5

`endif

// ---- pkg/pwc_pkg.sv ----
// Types of the power-on control block
package pwc_pkg;

  typedef enum logic [2:0] {
    PWC_STANDBY,
    PWC_SEQ,
    PWC_WAIT_PG,
    PWC_ON
  } pwc_state_e;

  typedef struct packed {
    logic [3:0] code;
    logic wr;
  } pwc_code_wr_s;

  typedef struct packed {
    pwc_state_e state;
    logic [31:0] tmr;
    logic [31:0] rtmr;
    logic [1:0] seq_idx;
    logic [8:0] en;
    logic [8:0] cmd_en;
    logic [3:0] core_code;
    logic [3:0] pad_code;
    logic [4:0][3:0] ln_code;
    logic rst_n;
    logic rst_running;
    logic boot_done;
    logic req_prev;
    logic pad_ok_s1;
    logic pad_ok_s2;
    logic [2:0] status;
    logic pwr_on;
    logic pg_prev;
    logic on;
  } pwc_state_s;

endpackage : pwc_pkg

// ---- design/pwc_power_on_control.sv ----
// Power-on sequencing, reset timing, regulator enables and voltage defaults
`timescale 1ns/1ps
`default_nettype none
`include "pwc_cfg.svh"

module pwc_power_on_control
  import pwc_pkg::*;
#(
  parameter int unsigned SEQ_STEP_CYC = `PWC_SEQ_STEP_CYC,
  parameter int unsigned RST_FIRST_CYC = `PWC_RST_FIRST_CYC,
  parameter int unsigned RST_LATER_CYC = `PWC_RST_LATER_CYC
) (
  // Clock and reset
  input wire logic clk_i,                 // 250 MHz clock
  input wire logic sys_rst_i,             // Synchronous reset, active high
  // Power-up requests and host handshake
  input wire logic power_key_i,           // Push-button request, active high
  input wire logic accessory_power_request_i, // Accessory request, active high
  input wire logic host_power_good_i,     // Host power-good
  input wire logic supply_ok_i,           // Supply in operating range
  // Analog monitors
  input wire logic pad_above_thresh_i,    // Pad output above 77 percent (async)
  input wire logic reset_event_i,         // Short, over-temp, undervoltage while on
  // Default voltage straps
  input wire logic core_voltage_strap_i,  // Core default select
  input wire logic pad_voltage_strap_i,   // Pad default select
  // Charger status inputs
  input wire logic charger_present_n_i,   // Charger present, active low
  input wire logic charging_n_i,          // Charging, active low
  input wire logic charger_fault_n_i,     // Charger fault, active low
  // Control writes, taken only while on
  input wire logic [8:0] enable_wdata_i,  // New on/off word
  input wire logic enable_wr_i,           // On/off word write strobe
  input wire pwc_code_wr_s core_code_wr_i, // Core voltage code write
  input wire pwc_code_wr_s pad_code_wr_i,  // Pad voltage code write
  input wire logic [2:0] ln_sel_i,        // Low-noise regulator select 0..4
  input wire pwc_code_wr_s ln_code_wr_i,   // Low-noise voltage code write
  // Regulator control
  output logic [8:0] regulator_enable_o,  // Regulator enables
  output logic [3:0] core_code_o,         // Core voltage code
  output logic [3:0] pad_code_o,          // Pad voltage code
  output logic [19:0] ln_code_o,          // Five low-noise voltage codes
  // Host reset, indicator and status
  output logic system_reset_n_o,          // Reset to host, active low
  output logic power_on_indicator_o,      // OR of key, accessory, power-good
  output logic [2:0] status_o,            // Charger status bits
  output logic powered_on_o               // Power-on latched
);

  ////////////////////////////////////////////////////////////////////////////
  // Whole block state: one registered copy and its next value
  pwc_state_s st_ff;
  pwc_state_s nxt_st;

  // Number of low-noise regulators and their code width
  localparam int unsigned LN_NUM = 5;
  localparam int unsigned LN_CODE_W = `PWC_CODE_W;

  // Sequence steps: index of the next default-on regulator to enable
  localparam logic [1:0] SEQ_PAD = 2'h1;
  localparam logic [1:0] SEQ_ANA = 2'h2;
  localparam logic [1:0] SEQ_OSC = 2'h3;

  // Codes above the top low-noise step are pinned to it
  // rather than wrapped, so a bad write never lowers the rail
  function automatic logic [3:0] clamp_ln(input logic [3:0] c);
    return (c > `PWC_LN_2V90) ? `PWC_LN_2V90 : c;
  endfunction : clamp_ln

  // Strap decode for the core and pad power-up defaults
  function automatic logic [3:0] core_default(input logic strap);
    return strap ? `PWC_CORE_1V80 : `PWC_CORE_1V35;
  endfunction : core_default

  function automatic logic [3:0] pad_default(input logic strap);
    return strap ? `PWC_PAD_2V60 : `PWC_PAD_1V80;
  endfunction : pad_default

  // Defaults on every shutdown; straps are read here only
  function automatic pwc_state_s defaults(input pwc_state_s s, input logic cs, input logic ps);
    pwc_state_s d;
    d = s;
    d.state = PWC_STANDBY;
    d.tmr = '0;
    d.seq_idx = '0;
    // Every regulator off; the on/off word returns to its default
    d.en = `PWC_EN_OFF;
    d.cmd_en = `PWC_EN_DEFAULT;
    // Voltage codes back to the strap-selected and fixed defaults
    d.core_code = core_default(cs);
    d.pad_code = pad_default(ps);
    for (int i = 0; i < LN_NUM; i++) begin
      d.ln_code[i] = `PWC_LN_DEFAULT;
    end
    // Reset output low with no count pending; the next release is a boot
    d.rst_n = 1'b0;
    d.rst_running = 1'b0;
    d.rtmr = '0;
    d.boot_done = 1'b0;
    return d;
  endfunction : defaults

  // Either source asks for power the same way
  logic req;
  assign req = power_key_i | accessory_power_request_i;

  // Causes outside the enables that hold the reset output low
  logic rst_cause;
  assign rst_cause = reset_event_i | ~st_ff.pad_ok_s2;

  // Sequence step due: the spacing count has run out
  logic seq_due;
  assign seq_due = (st_ff.tmr == '0);

  // A start needs a fresh rising request and a supply in range; a level
  // that was already high when standby was entered does not restart
  function automatic logic start_edge(input logic r, input logic r_prev, input logic sup);
    return r && !r_prev && sup;
  endfunction : start_edge

  // A running count is brought down by one each edge and rests at zero
  function automatic logic [31:0] count_down(input logic [31:0] t);
    return (t != '0) ? (t - 32'h1) : t;
  endfunction : count_down

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.
  // Standby waits for a start edge. The sequence turns on core, pad,
  // analog and oscillator one step apart, then waits for power-good with
  // no time limit. Losing the request before power-good abandons the
  // start. Once on, only a falling power-good shuts down; key edges and
  // the accessory input are then ignored. The reset output is timed in
  // its own section below, apart from the state flow.
  always_comb begin
    // Hold everything unless a section below changes it
    nxt_st = st_ff;

    // Edge history and input sampling run in every state
    nxt_st.req_prev = req;
    nxt_st.pg_prev = host_power_good_i;
    // Two-flop synchroniser; only the second stage is read
    nxt_st.pad_ok_s1 = pad_above_thresh_i;
    nxt_st.pad_ok_s2 = st_ff.pad_ok_s1;
    nxt_st.pwr_on = power_key_i | accessory_power_request_i | host_power_good_i;
    // Charger inputs arrive active low; status bits read active high
    nxt_st.status[`PWC_ST_PRESENT] = ~charger_present_n_i;
    nxt_st.status[`PWC_ST_CHARGING] = ~charging_n_i;
    nxt_st.status[`PWC_ST_FAULT] = ~charger_fault_n_i;

    // Both counts run from the clock itself; the sequence timer and the
    // reset timer are kept apart so that a reset count started by the pad
    // threshold in the middle of the sequence cannot stretch the spacing
    nxt_st.tmr = count_down(st_ff.tmr);
    nxt_st.rtmr = count_down(st_ff.rtmr);

    unique case (st_ff.state)
      PWC_STANDBY: begin
        // Straps are read at this edge and held until shutdown
        if (start_edge(req, st_ff.req_prev, supply_ok_i)) begin
          nxt_st = defaults(nxt_st, core_voltage_strap_i, pad_voltage_strap_i);
          nxt_st.state = PWC_SEQ;
          nxt_st.en[`PWC_EN_CORE] = 1'b1;
          nxt_st.seq_idx = SEQ_PAD;
          nxt_st.tmr = SEQ_STEP_CYC;
        end
      end
      PWC_SEQ: begin
        // Request lost before power-good: back to standby
        if (!req) begin
          nxt_st = defaults(nxt_st, core_voltage_strap_i, pad_voltage_strap_i);
        end else if (seq_due) begin
          // Each step enables the next default-on regulator
          unique case (st_ff.seq_idx)
            SEQ_PAD: nxt_st.en[`PWC_EN_PAD] = 1'b1;
            SEQ_ANA: nxt_st.en[`PWC_EN_ANA] = 1'b1;
            SEQ_OSC: nxt_st.en[`PWC_EN_OSC] = 1'b1;
            default: ;
          endcase
          nxt_st.seq_idx = st_ff.seq_idx + 2'h1;
          nxt_st.tmr = SEQ_STEP_CYC;
          if (st_ff.seq_idx == SEQ_OSC) begin
            nxt_st.state = PWC_WAIT_PG;
            nxt_st.tmr = '0;
          end
        end
      end
      PWC_WAIT_PG: begin
        // No timeout: waits as long as the request is held
        if (!req) begin
          nxt_st = defaults(nxt_st, core_voltage_strap_i, pad_voltage_strap_i);
        end else if (host_power_good_i) begin
          nxt_st.state = PWC_ON;
        end
      end
      PWC_ON: begin
        if (!host_power_good_i) begin
          nxt_st = defaults(nxt_st, core_voltage_strap_i, pad_voltage_strap_i);
        end else begin
          // Key activity is ignored here
          // Writes touch only their own field; everything else is kept
          if (enable_wr_i) begin
            nxt_st.cmd_en = enable_wdata_i;
            nxt_st.en = enable_wdata_i;
          end
          if (core_code_wr_i.wr) begin
            nxt_st.core_code = core_code_wr_i.code;
          end
          if (pad_code_wr_i.wr) begin
            nxt_st.pad_code = pad_code_wr_i.code;
          end
          if (ln_code_wr_i.wr && ({29'h0, ln_sel_i} < LN_NUM)) begin
            nxt_st.ln_code[ln_sel_i] = clamp_ln(ln_code_wr_i.code);
          end
        end
      end
    endcase

    // Reset output timing, shared by power-up and on states.
    // Any live cause holds the output low and drops a running count, so a
    // cause that clears and returns always restarts the full delay.
    if (st_ff.state != PWC_STANDBY && nxt_st.state != PWC_STANDBY) begin
      if (rst_cause || !nxt_st.en[`PWC_EN_PAD]) begin
        nxt_st.rst_n = 1'b0;
        nxt_st.rst_running = 1'b0;
        nxt_st.rtmr = '0;
      end else if (!st_ff.rst_n && !st_ff.rst_running) begin
        // First release after a start uses the boot delay; later ones
        // use the longer hold
        nxt_st.rst_running = 1'b1;
        nxt_st.rtmr = st_ff.boot_done ? RST_LATER_CYC : RST_FIRST_CYC;
      end else if (st_ff.rst_running && st_ff.rtmr == '0) begin
        // Count ran out with no cause present: release
        nxt_st.rst_running = 1'b0;
        nxt_st.rst_n = 1'b1;
        nxt_st.boot_done = 1'b1;
      end
    end

    // Registered copy of the on state, so the flag leaves a flip-flop
    nxt_st.on = (nxt_st.state == PWC_ON);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Synchronous reset clears the whole state: standby, reset output low
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign regulator_enable_o = st_ff.en;
  assign core_code_o = st_ff.core_code;
  assign pad_code_o = st_ff.pad_code;

  // Low-noise codes laid out four bits per regulator, lowest first
  for (genvar g = 0; g < LN_NUM; g++) begin : g_ln_out
    assign ln_code_o[g*LN_CODE_W +: LN_CODE_W] = st_ff.ln_code[g];
  end

  // Host-facing outputs, each straight from the state register
  assign system_reset_n_o = st_ff.rst_n;
  assign power_on_indicator_o = st_ff.pwr_on;
  assign status_o = st_ff.status;
  assign powered_on_o = st_ff.on;

endmodule : pwc_power_on_control
`default_nettype wire

// ---- testbench/pwc_power_on_control_chk.sv ----
// Concurrent checks on the power-on control block ports
`timescale 1ns/1ps
`default_nettype none
module pwc_power_on_control_chk
  import pwc_pkg::*;
#(parameter int unsigned SEQ_STEP_CYC = 10, RST_FIRST_CYC = 50, RST_LATER_CYC = 80) (
  input wire logic clk_i, // Clock
  input wire logic sys_rst_i, // Reset
  input wire logic power_key_i, // Key
  input wire logic accessory_power_request_i, // Accessory
  input wire logic host_power_good_i, // Power-good
  input wire logic supply_ok_i, // Supply in range
  input wire logic pad_above_thresh_i, // Pad threshold
  input wire logic reset_event_i, // Reset cause
  input wire logic charger_present_n_i, // Charger present
  input wire logic charging_n_i, // Charging
  input wire logic charger_fault_n_i, // Fault
  input wire logic enable_wr_i, // Enable write
  input wire logic [8:0] regulator_enable_o, // Enables
  input wire logic [19:0] ln_code_o, // Low-noise codes
  input wire logic system_reset_n_o, // Reset out
  input wire logic power_on_indicator_o, // OR output
  input wire logic [2:0] status_o, // Status
  input wire logic powered_on_o // On state
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  a_or_output: assert property (!$past(sys_rst_i) |-> power_on_indicator_o ==
    $past(power_key_i | accessory_power_request_i | host_power_good_i)) else $error("OR output wrong");
  a_status_map: assert property (!$past(sys_rst_i) |-> status_o ==
    ~$past({charger_fault_n_i, charging_n_i, charger_present_n_i})) else $error("status bits wrong");
  a_pg_off: assert property (powered_on_o && !host_power_good_i |=> !powered_on_o && !system_reset_n_o &&
    regulator_enable_o == 9'h000) else $error("no shutdown on power-good low");
  a_key_ignored: assert property (powered_on_o && host_power_good_i && !enable_wr_i |=>
    $stable(regulator_enable_o)) else $error("enables moved while on");
  a_start_supply: assert property ($rose(regulator_enable_o[0]) && !$past(powered_on_o) |->
    $past(supply_ok_i) || $past(supply_ok_i, 2)) else $error("start without supply");
  a_latch_on: assert property ($rose(powered_on_o) |-> $past(host_power_good_i) &&
    $past(regulator_enable_o[3:0]) == 4'hf) else $error("latched on too early");
  a_event_hold: assert property (reset_event_i |=> !system_reset_n_o) else $error("reset not held");
  a_pad_gate: assert property ($rose(system_reset_n_o) |-> $past(pad_above_thresh_i, 8) &&
    $past(regulator_enable_o[1])) else $error("reset released without pad");
  a_ln_range: assert property ((ln_code_o & 20'h88888) == 20'h00000) else $error("code out of range");
endmodule : pwc_power_on_control_chk
bind pwc_power_on_control pwc_power_on_control_chk #(.SEQ_STEP_CYC(SEQ_STEP_CYC), .RST_FIRST_CYC(RST_FIRST_CYC),
  .RST_LATER_CYC(RST_LATER_CYC)) u_chk (.*);
`default_nettype wire

// ---- testbench/pwc_host_model.sv ----
// Host model: raises power-good after reset release, loses it with the core supply
`timescale 1ns/1ps
`default_nettype none
module pwc_host_model (
  input wire logic clk_i, // Clock
  input wire logic sys_rst_i, // Reset
  input wire logic allow_i, // Host willing to hold power on
  input wire logic reset_n_i, // Reset from device
  input wire logic core_en_i, // Core supply of the host
  output var logic power_good_o // Power-good to device
);
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !core_en_i) begin
      power_good_o <= 1'b0;
    end else if (allow_i && reset_n_i) begin
      power_good_o <= 1'b1;
    end
  end
endmodule : pwc_host_model
`default_nettype wire

// ---- testbench/pwc_power_on_control_tb.sv ----
// Self-checking bench of the power-on control block
`timescale 1ns/1ps
`default_nettype none
module pwc_power_on_control_tb;
  import pwc_pkg::*;
  localparam int SQ = 10;
  logic clk_i = 0, sys_rst_i = 1, key = 0, acc = 0, sup = 0, pad = 0, rev = 0, cs = 1, ps = 0, allow = 0, we = 0;
  logic [2:0] chg = 3'h7, sel = 3'h0, st;
  logic [8:0] wd = 9'h000, en;
  pwc_code_wr_s cw = '0, pw = '0, lw = '0;
  logic [3:0] cc, pc;
  logic [19:0] ln;
  logic pg, rn, pon, pwd;
  int mismatches = 0, checked = 0, cyc = 0, n;
  pwc_power_on_control #(.SEQ_STEP_CYC(SQ), .RST_FIRST_CYC(50), .RST_LATER_CYC(80)) DUT (.clk_i(clk_i),
    .sys_rst_i(sys_rst_i), .power_key_i(key), .accessory_power_request_i(acc), .host_power_good_i(pg),
    .supply_ok_i(sup), .pad_above_thresh_i(pad), .reset_event_i(rev), .core_voltage_strap_i(cs),
    .pad_voltage_strap_i(ps), .charger_present_n_i(chg[0]), .charging_n_i(chg[1]), .charger_fault_n_i(chg[2]),
    .enable_wdata_i(wd), .enable_wr_i(we), .core_code_wr_i(cw), .pad_code_wr_i(pw), .ln_sel_i(sel),
    .ln_code_wr_i(lw), .regulator_enable_o(en), .core_code_o(cc), .pad_code_o(pc), .ln_code_o(ln),
    .system_reset_n_o(rn), .power_on_indicator_o(pon), .status_o(st), .powered_on_o(pwd));
  pwc_host_model HST (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .allow_i(allow), .reset_n_i(rn), .core_en_i(en[0]),
    .power_good_o(pg));
  initial forever #2 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 6000) begin
      mismatches++;
      finish_test();
    end
  end
  task automatic finish_test();
    if (mismatches == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic tk(input int k);
    repeat (k) @(negedge clk_i);
  endtask : tk
  // Counts cycles until the enables (r=0) or the reset output (r=1) reach v
  task automatic wt(input logic [8:0] v, input logic r);
    n = 0;
    while ((r ? {8'h00, rn} : en) !== v && n < 400) begin
      tk(1);
      n++;
    end
  endtask : wt
  initial begin
    tk(12);
    sys_rst_i = 0;
    chk({en, rn, pon}, 11'h000);
    key = 1;
    tk(5);
    chk(en, 9'h000);
    key = 0;
    sup = 1;
    tk(2);
    key = 1;
    wt(9'h001, 0);
    chk(n <= 2, 1);
    chk({cc, pc, ln}, {4'h3, 4'h3, 20'h55555});
    wt(9'h003, 0);
    chk(n, SQ + 1);
    wt(9'h007, 0);
    chk(n, SQ + 1);
    wt(9'h00f, 0);
    chk(n, SQ + 1);
    tk(3);
    key = 0;
    tk(3);
    chk(en, 9'h000);
    cs = 0;
    ps = 1;
    allow = 1;
    acc = 1;
    tk(3);
    chk({cc, pc}, 8'h08);
    wt(9'h003, 0);
    pad = 1;
    wt(1, 1);
    chk(n >= 50 && n <= 56, 1);
    tk(10);
    acc = 0;
    cs = 1;
    ps = 0;
    key = 1;
    chg = 3'h2;
    tk(4);
    chk({pwd, en, cc, pc, pon, st}, {1'b1, 9'h00f, 4'h0, 4'h8, 1'b1, 3'h5});
    key = 0;
    pw = '{code: 4'h5, wr: 1'b1};
    sel = 3'h2;
    lw = '{code: 4'hf, wr: 1'b1};
    tk(1);
    pw.wr = 0;
    lw.wr = 0;
    wd = 9'h1ff;
    we = 1;
    tk(1);
    we = 0;
    tk(2);
    chk({en, pc, ln}, {9'h1ff, 4'h5, 20'h55755});
    rev = 1;
    tk(2);
    chk(rn, 0);
    rev = 0;
    wt(1, 1);
    chk(n >= 80 && n <= 86, 1);
    wd = 9'h000;
    we = 1;
    tk(1);
    we = 0;
    tk(8);
    chk({pwd, en, rn, pc, cc}, {1'b0, 9'h000, 1'b0, 4'h3, 4'h3});
    finish_test();
  end
endmodule : pwc_power_on_control_tb
`default_nettype wire
